/* design/iuvf_fault_response.sv */
// Input-undervoltage fault response: threshold, policy, retries.
// Assumes synchronous inputs and a linear-11 input voltage reading.
`timescale 1ns/1ns
`default_nettype none
module iuvf_fault_response #(
  parameter int RETRY_UNIT_CYC = iuvf_pkg::RETRY_UNIT_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Command port
  input wire iuvf_pkg::iuvf_cmd_s cmd,
  input wire logic clearFaults,
  output logic [15:0] rdData,
  output logic rdValid,
  // Voltages
  input wire logic [15:0] vinReading,
  input wire logic [15:0] warnThreshold,
  input wire logic [15:0] strapLockout,
  // Power stage control
  input wire logic enableReq,
  input wire logic otherFault,
  output logic outputEnable,
  // Status
  output logic uvFaultFlag,
  output logic hostAlertLine_n
);

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic signed [iuvf_pkg::FIX_W-1:0] linToFix(input logic [15:0] w);
    logic signed [iuvf_pkg::FIX_W-1:0] m;
    logic signed [5:0] sh;
    logic signed [5:0] nsh;
    m = iuvf_pkg::FIX_W'(signed'(w[10:0]));
    sh = 6'(signed'(w[15:11])) + 6'sh08;
    nsh = -sh;
    if (sh >= 0) begin
      linToFix = m <<< sh[4:0];
    end else begin
      linToFix = m >>> nsh[4:0];
    end
  endfunction

  logic [15:0] threshold;
  logic [7:0] action;
  logic bootPending;
  iuvf_pkg::iuvf_state_e state;
  iuvf_pkg::iuvf_state_e next_state;
  logic uvNow;
  logic recovered;
  logic [1:0] resp;
  logic [2:0] retry;
  logic retryMode;
  logic timerStart;
  logic timerDone;
  logic [iuvf_pkg::TIMER_W-1:0] retryTarget;
  logic [iuvf_pkg::TIMER_W-1:0] dlyCnt;

  assign resp = action[iuvf_pkg::RESP_HI:iuvf_pkg::RESP_LO];
  assign retry = action[iuvf_pkg::RETRY_HI:iuvf_pkg::RETRY_LO];
  assign retryMode = (resp == iuvf_pkg::RESP_RETRY) && (retry == iuvf_pkg::RETRY_ALWAYS);
  assign uvNow = linToFix(vinReading) < linToFix(threshold);
  assign recovered = linToFix(vinReading) > linToFix(warnThreshold);
  assign retryTarget = iuvf_pkg::TIMER_W'(
      (32'(action[iuvf_pkg::DELAY_HI:iuvf_pkg::DELAY_LO]) + 32'h1) * 32'(RETRY_UNIT_CYC));

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      threshold <= iuvf_pkg::THRESHOLD_PRESET;
      action <= iuvf_pkg::ACTION_RESET;
      bootPending <= 1'b1;
    end else begin
      bootPending <= 1'b0;
      if (bootPending) begin
        threshold <= strapLockout;
      end else if (cmd.wr && cmd.code == iuvf_pkg::CODE_FAULT_THRESHOLD) begin
        threshold <= cmd.data;
      end
      if (cmd.wr && cmd.code == iuvf_pkg::CODE_FAULT_ACTION) begin
        action <= cmd.data[7:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdData <= 16'h0000;
      rdValid <= 1'b0;
    end else begin
      rdValid <= cmd.rd;
      if (cmd.rd) begin
        case (cmd.code)
          iuvf_pkg::CODE_FAULT_THRESHOLD: rdData <= threshold;
          iuvf_pkg::CODE_FAULT_ACTION: rdData <= {8'h00, action};
          default: rdData <= 16'h0000;
        endcase
      end
    end
  end

  // ************************************************************
  // Fault flag and alert
  // ************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      uvFaultFlag <= 1'b0;
      hostAlertLine_n <= 1'b1;
    end else if (state == iuvf_pkg::ST_ON && uvNow) begin
      uvFaultFlag <= 1'b1;
      hostAlertLine_n <= 1'b0;
    end else if (clearFaults) begin
      uvFaultFlag <= 1'b0;
      hostAlertLine_n <= 1'b1;
    end
  end

  // ************************************************************
  // Response state machine
  // ************************************************************
  always_comb begin
    next_state = state;
    timerStart = 1'b0;
    case (state)
      iuvf_pkg::ST_ON: begin
        if (uvNow) begin
          if (resp == iuvf_pkg::RESP_WHILE_PRESENT || retryMode) begin
            next_state = iuvf_pkg::ST_FAULT;
          end else begin
            next_state = iuvf_pkg::ST_LOCK;
          end
        end
      end
      iuvf_pkg::ST_FAULT: begin
        if (!enableReq || otherFault) begin
          next_state = iuvf_pkg::ST_ON;
        end else if (recovered) begin
          if (resp == iuvf_pkg::RESP_WHILE_PRESENT) begin
            next_state = iuvf_pkg::ST_ON;
          end else if (retryMode) begin
            next_state = iuvf_pkg::ST_DELAY;
            timerStart = 1'b1;
          end else begin
            next_state = iuvf_pkg::ST_LOCK;
          end
        end
      end
      iuvf_pkg::ST_DELAY: begin
        if (!enableReq || otherFault) begin
          next_state = iuvf_pkg::ST_ON;
        end else if (timerDone) begin
          next_state = iuvf_pkg::ST_ON;
        end
      end
      iuvf_pkg::ST_LOCK: begin
        if (clearFaults) begin
          next_state = iuvf_pkg::ST_ON;
        end
      end
      default: next_state = iuvf_pkg::ST_LOCK;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= iuvf_pkg::ST_ON;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      outputEnable <= 1'b0;
    end else begin
      outputEnable <= (next_state == iuvf_pkg::ST_ON) && enableReq && !otherFault;
    end
  end

  iuvf_retry_timer u_timer (
    .clk(clk),
    .srst(srst),
    .start(timerStart),
    .target(retryTarget),
    .done(timerDone)
  );

  // ************************************************************
  // Checks
  // ************************************************************
  always_ff @(posedge clk) begin
    if (srst || state != iuvf_pkg::ST_DELAY) begin
      dlyCnt <= 24'h000000;
    end else begin
      dlyCnt <= dlyCnt + 24'h000001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_fault_seen;
    state == iuvf_pkg::ST_ON && uvNow;
  endsequence

  sequence s_recovering;
    state == iuvf_pkg::ST_FAULT && recovered && enableReq && !otherFault;
  endsequence

  chk_fault_flag_set: assert property (s_fault_seen |=> uvFaultFlag && !hostAlertLine_n)
    else $error("fault not flagged");
  chk_alert_matches_flag: assert property (hostAlertLine_n == !uvFaultFlag)
    else $error("alert and flag disagree");
  chk_flag_sticky: assert property (uvFaultFlag && !clearFaults |=> uvFaultFlag)
    else $error("fault flag lost");
  chk_lock_holds_off: assert property (
      state == iuvf_pkg::ST_LOCK && !clearFaults |=> !outputEnable && state == iuvf_pkg::ST_LOCK)
    else $error("locked output came back");
  chk_reserved_locks: assert property (
      s_fault_seen ##0 (resp != iuvf_pkg::RESP_WHILE_PRESENT && !retryMode)
      |=> state == iuvf_pkg::ST_LOCK)
    else $error("reserved code did not lock");
  chk_hold_until_warn: assert property (
      state == iuvf_pkg::ST_FAULT && !recovered |=> !outputEnable)
    else $error("output on before recovery");
  chk_resume_on_warn: assert property (
      s_recovering ##0 resp == iuvf_pkg::RESP_WHILE_PRESENT
      |=> state == iuvf_pkg::ST_ON && outputEnable)
    else $error("no resume above warning");
  chk_retry_after_warn: assert property (
      state == iuvf_pkg::ST_FAULT && !recovered |=> state != iuvf_pkg::ST_DELAY)
    else $error("retry before recovery");
  chk_retry_spacing: assert property (
      state == iuvf_pkg::ST_DELAY && timerDone |-> dlyCnt == retryTarget)
    else $error("retry spacing wrong");
  chk_retry_stops: assert property (
      (state == iuvf_pkg::ST_DELAY || state == iuvf_pkg::ST_FAULT) && !enableReq
      |=> state == iuvf_pkg::ST_ON && !outputEnable)
    else $error("retry not stopped");
  chk_strap_load: assert property ($past(srst) |=> threshold == $past(strapLockout))
    else $error("threshold not strapped");
  chk_action_reset: assert property ($past(srst) |-> action == iuvf_pkg::ACTION_RESET)
    else $error("action reset wrong");
  chk_retry_mode_path: assert property (
      s_recovering ##0 retryMode |=> state == iuvf_pkg::ST_DELAY ##1 !outputEnable)
    else $error("retry path wrong");
  chk_compare: assert property (
      vinReading[15:11] == 5'h00 && threshold[15:11] == 5'h00
      |-> uvNow == ($signed(vinReading[10:0]) < $signed(threshold[10:0])))
    else $error("compare wrong");

endmodule
`default_nettype wire

/* design/iuvf_pkg.sv */
// Constants and types for the input-undervoltage fault response block.
// Assumes a 25 MHz system clock and linear-11 voltage words.
package iuvf_pkg;

  // ************************************************************
  // Command codes
  // ************************************************************
  localparam logic [7:0] CODE_FAULT_THRESHOLD = 8'h59;
  localparam logic [7:0] CODE_FAULT_ACTION = 8'h5a;

  // ************************************************************
  // Reset values and field positions
  // ************************************************************
  localparam logic [7:0] ACTION_RESET = 8'hbf;
  localparam logic [15:0] THRESHOLD_PRESET = 16'h0000;
  localparam int RESP_HI = 7;
  localparam int RESP_LO = 6;
  localparam int RETRY_HI = 5;
  localparam int RETRY_LO = 3;
  localparam int DELAY_HI = 2;
  localparam int DELAY_LO = 0;
  localparam logic [1:0] RESP_RETRY = 2'h2;
  localparam logic [1:0] RESP_WHILE_PRESENT = 2'h3;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_ALWAYS = 3'h7;

  // ************************************************************
  // Linear format and timing
  // ************************************************************
  localparam int FIX_FRAC = 8;
  localparam int FIX_W = 40;
  localparam int CLK_HZ = 25_000_000;
  localparam int RETRY_UNIT_MS = 35;
  localparam int RETRY_UNIT_CYC = RETRY_UNIT_MS * (CLK_HZ / 1000);
  localparam int TIMER_W = 24;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    ST_ON = 2'h0,
    ST_FAULT = 2'h1,
    ST_DELAY = 2'h3,
    ST_LOCK = 2'h2
  } iuvf_state_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] code;
    logic [15:0] data;
  } iuvf_cmd_s;

endpackage

/* design/iuvf_retry_timer.sv */
// Retry spacing timer for the undervoltage fault response.
// Assumes start is a one-cycle pulse and target is at least one.
`timescale 1ns/1ns
`default_nettype none
module iuvf_retry_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Control
  input wire logic start,
  input wire logic [iuvf_pkg::TIMER_W-1:0] target,
  // Result
  output logic done
);

  logic [iuvf_pkg::TIMER_W-1:0] count;
  logic running;

  // ************************************************************
  // Down counter
  // ************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      count <= 24'h000000;
      running <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count <= target - 24'h000001;
        running <= 1'b1;
      end else if (running) begin
        if (count == 24'h000000) begin
          running <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count - 24'h000001;
        end
      end
    end
  end

endmodule
`default_nettype wire

/* dv/iuvf_host_model.sv */
// Host controller model: issues register commands and clear-faults.
// Assumes the device answers a read with rdValid one cycle later.
`timescale 1ns/1ns
`default_nettype none
module iuvf_host_model (
  // Clock
  input wire logic clk,
  // Device answer
  input wire logic [15:0] rdData,
  input wire logic rdValid,
  // Requests
  output var iuvf_pkg::iuvf_cmd_s cmd,
  output logic clearFaults
);
  // ************************************************************
  // Command sequencing
  // ************************************************************
  logic [15:0] lastRead;
  initial begin
    cmd = '0;
    clearFaults = 1'b0;
    lastRead = 16'h0000;
  end
  // One-cycle strobe; idle code and data carry a changed pattern
  task automatic access(input logic wr, input logic [7:0] code, input logic [15:0] data);
    @(negedge clk);
    cmd = {wr, !wr, code, data};
    @(negedge clk);
    cmd = {1'b0, 1'b0, ~code, ~data};
    lastRead = rdValid === 1'b1 ? rdData : 16'hxxxx;
  endtask
  // Clear-faults pulse
  task automatic clear();
    @(negedge clk);
    clearFaults = 1'b1;
    @(negedge clk);
    clearFaults = 1'b0;
  endtask
endmodule
`default_nettype wire

/* dv/iuvf_fault_response_bench.sv */
// Self-checking bench for the undervoltage fault response block.
// Assumes the host model file is compiled first; retry unit is 4 cycles.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin nChecks++; if ((got) !== (ex)) begin nFail++; $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module iuvf_fault_response_bench;
  // ************************************************************
  // Signals and instances
  // ************************************************************
  localparam int UNIT = 4;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [15:0] vin = 16'h000e;
  logic [15:0] warn = 16'h000c;
  logic [15:0] strap = 16'h000a;
  logic enableReq = 1'b1;
  logic otherFault = 1'b0;
  iuvf_pkg::iuvf_cmd_s cmd;
  logic clearFaults, rdValid, oe, flag, alert_n;
  logic [15:0] rdData;
  logic [31:0] lfsr = 32'he309eb1a;
  int nFail = 0;
  int nChecks = 0;
  int cyc = 0;
  int k, k0;
  logic [7:0] acts [14] = '{8'hb8, 8'hb9, 8'hba, 8'hbb, 8'hbc, 8'hbd, 8'hbe, 8'hbf,
    8'hc0, 8'h80, 8'h00, 8'h40, 8'h88, 8'hb0};
  always #20 clk = ~clk;
  iuvf_host_model host (.clk(clk), .rdData(rdData), .rdValid(rdValid), .cmd(cmd),
    .clearFaults(clearFaults));
  iuvf_fault_response #(.RETRY_UNIT_CYC(UNIT)) dut (.clk(clk), .srst(srst), .cmd(cmd),
    .clearFaults(clearFaults), .rdData(rdData), .rdValid(rdValid), .vinReading(vin),
    .warnThreshold(warn), .strapLockout(strap), .enableReq(enableReq), .otherFault(otherFault),
    .outputEnable(oe), .uvFaultFlag(flag), .hostAlertLine_n(alert_n));
  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // 2 timed retry, 1 follow warning, 0 locked off
  function automatic int mode(input logic [7:0] a);
    if (a[7:6] == iuvf_pkg::RESP_WHILE_PRESENT) return 1;
    if (a[7:6] == iuvf_pkg::RESP_RETRY && a[5:3] == iuvf_pkg::RETRY_ALWAYS) return 2;
    return 0;
  endfunction
  task automatic summarize();
    if (nFail == 0 && nChecks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      nFail++;
      summarize();
    end
  end
  // Trip a fault, sit between limits, then recover; k counts cycles to output on
  task automatic trip();
    @(negedge clk);
    vin = 16'h0008;
    k = 0;
    while (flag !== 1'b1 && k < 4) begin
      @(negedge clk);
      k++;
    end
    `CHK("flag", 1'b1, flag)
    `CHK("alert", 1'b0, alert_n)
    `CHK("oeFault", 1'b0, oe)
    vin = 16'h000b;
    repeat (10) @(negedge clk);
    `CHK("oeMid", 1'b0, oe)
    vin = 16'h000e;
    k = 0;
    while (oe !== 1'b1 && k < 60) begin
      @(negedge clk);
      k++;
    end
    `CHK("flagHeld", 1'b1, flag)
  endtask
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    host.access(1'b0, iuvf_pkg::CODE_FAULT_ACTION, 16'h0000);
    `CHK("actReset", 16'h00bf, host.lastRead)
    host.access(1'b0, iuvf_pkg::CODE_FAULT_THRESHOLD, 16'h0000);
    `CHK("thrStrap", strap, host.lastRead)
    host.access(1'b0, 8'h33, 16'h0000);
    `CHK("unmapped", 16'h0000, host.lastRead)
    repeat (4) begin
      lfsr = step(lfsr);
      host.access(1'b1, iuvf_pkg::CODE_FAULT_THRESHOLD, {5'h00, 11'(lfsr % 13 + 1)});
      host.access(1'b0, iuvf_pkg::CODE_FAULT_THRESHOLD, 16'h0000);
      `CHK("thrRw", {5'h00, 11'(lfsr % 13 + 1)}, host.lastRead)
    end
    host.access(1'b1, iuvf_pkg::CODE_FAULT_THRESHOLD, 16'h000a);
    for (int i = 0; i < 14; i++) begin
      host.access(1'b1, iuvf_pkg::CODE_FAULT_ACTION, {8'h00, acts[i]});
      host.access(1'b0, iuvf_pkg::CODE_FAULT_ACTION, 16'h0000);
      `CHK("actRw", {8'h00, acts[i]}, host.lastRead)
      trip();
      if (mode(acts[i]) == 2) begin
        if (i == 0) k0 = k;
        `CHK("spacing", UNIT * int'(acts[i][2:0]), k - k0)
        `CHK("retried", 1'b1, oe)
      end else if (mode(acts[i]) == 1) begin
        `CHK("follow", 1'b1, k <= 3)
      end else begin
        `CHK("locked", 1'b0, oe)
      end
      host.clear();
      repeat (3) @(negedge clk);
      `CHK("flagClr", 1'b0, flag)
      `CHK("alertClr", 1'b1, alert_n)
      `CHK("oeBack", 1'b1, oe)
    end
    // Enable pin stops a pending retry; other fault then holds the output off
    host.access(1'b1, iuvf_pkg::CODE_FAULT_ACTION, 16'h00bf);
    vin = 16'h0008;
    @(negedge clk);
    vin = 16'h000e;
    repeat (2) @(negedge clk);
    enableReq = 1'b0;
    repeat (60) @(negedge clk);
    `CHK("offByPin", 1'b0, oe)
    `CHK("flagKept", 1'b1, flag)
    enableReq = 1'b1;
    otherFault = 1'b1;
    repeat (3) @(negedge clk);
    `CHK("offByFault", 1'b0, oe)
    otherFault = 1'b0;
    repeat (3) @(negedge clk);
    `CHK("backOn", 1'b1, oe)
    summarize();
  end
endmodule
`default_nettype wire
